// ### rtl/counter_array_pkg.sv
// Constants, field layouts and carrier types of the counter array block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package counter_array_pkg;

   localparam int N_MOD = 5;

   // Register byte addresses
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_TLOW   = 8'h08;
   localparam logic [7:0] ADR_THIGH  = 8'h0c;
   // Per-module window: address bits [7:4] select, bits [3:0] are the offset
   localparam logic [3:0] MOD_FIRST  = 4'h2;
   localparam logic [3:0] OFS_MODE   = 4'h0;
   localparam logic [3:0] OFS_CLOW   = 4'h4;
   localparam logic [3:0] OFS_CHIGH  = 4'h8;
   localparam logic [3:0] OFS_DUTY   = 4'hc;

   // Control register fields
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_SEL_LSB  = 1;
   localparam int CTRL_FLAG_LSB = 8;

   // Mode register fields
   localparam int MODE_IRQ_BIT   = 0;
   localparam int MODE_PWM_BIT   = 1;
   localparam int MODE_MATCH_BIT = 3;
   localparam int MODE_CE_BIT    = 6;

   // Timer source dividers, one per clock select code
   localparam logic [7:0] DIV_SEL0 = 8'h01;
   localparam logic [7:0] DIV_SEL1 = 8'h04;
   localparam logic [7:0] DIV_SEL2 = 8'h0c;
   localparam logic [7:0] DIV_SEL3 = 8'h40;

   // Reset values and the timer low-byte maximum
   localparam logic [15:0] TIMER_RST = 16'h0000;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;
   localparam logic [7:0]  LOW_MAX   = 8'hff;

   typedef logic [N_MOD-1:0] mod_vec_t;

   typedef struct packed {
      logic compare_enable;
      logic match_enable;
      logic pwm_mode;
      logic module_event_irq_enable;
   } module_mode_t;

   localparam module_mode_t MODE_RST = '{default: 1'b0};

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic [7:0] duty_active_byte;
      logic       match;
      logic       pin;
   } chan_state_t;

endpackage

// ### rtl/compare_pwm_channel.sv
// One compare / pulse-width module sharing the array timer.
// Assumes timer, update and rollover strobes come from the same clock.
`timescale 1ns/1ps
module compare_pwm_channel (
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   input  wire counter_array_pkg::module_mode_t mode,
   input  wire logic [7:0]                   compare_low_byte,
   input  wire logic [7:0]                   compare_high_byte,
   input  wire logic [15:0]                  timer,
   input  wire logic                         timer_upd,
   input  wire logic                         rollover,
   output logic                              match,
   output logic                              pwm_pin,
   output logic [7:0]                        duty_active_byte
);

   counter_array_pkg::chan_state_t st_r;
   counter_array_pkg::chan_state_t st_nxt;
   logic                           pwm_on;

   always_comb begin
      st_nxt = st_r;
      pwm_on = mode.pwm_mode & mode.compare_enable; // R12
      if (rollover) begin
         st_nxt.duty_active_byte = compare_high_byte; // R11
      end
      // Only checked once per new timer value so a match pulses once
      st_nxt.match = mode.compare_enable & mode.match_enable & timer_upd
                     & (timer == {compare_high_byte, compare_low_byte}); // R01
      st_nxt.pin = pwm_on & (timer[7:0] >= st_r.duty_active_byte); // R10
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{duty_active_byte: counter_array_pkg::BYTE_RST, match: 1'b0, pin: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign match            = st_r.match;
   assign pwm_pin          = st_r.pin; // R15
   assign duty_active_byte = st_r.duty_active_byte;

endmodule

// ### rtl/counter_array.sv
// Counter array: shared 16-bit timer, compare and PWM modules, Wishbone slave.
// Assumes a classic Wishbone master on the same clock; pins go off-chip.
//
// Summary of operation
// R01 - Module is a 16-bit compare timer when compare-enable and match bits set.
// R02 - Timer matches compare pair; request raised when flag and enable both set.
// R03 - Software loads nonzero compare bytes before enabling compare.
// R04 - Writing low compare byte clears that module's compare-enable.
// R05 - Writing high compare byte sets that module's compare-enable.
// R06 - Software writes low compare byte first, then high byte.
// R07 - Compare-enable stays readable and writable in the mode register.
// R08 - Every module can drive PWM; all share one timer frequency.
// R09 - Timer clock source selection sets the PWM period of all modules.
// R10 - PWM pin low while timer low byte below duty byte, else high.
// R11 - Duty byte reloaded from high compare byte when low byte rolls over.
// R12 - PWM enabled only with pulse-width mode and compare-enable both set.
// R13 - Shared timer is high and low byte, readable, resets to zero.
// R14 - Match sets the module event flag, held until software clears it.
// R15 - PWM waveform drives the module's dedicated output pin.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module counter_array (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire counter_array_pkg::wb_req_t    wb_req,
   output logic [31:0]                        wb_dat_r,
   output logic                               wb_ack,
   output logic                               event_irq,
   output logic [counter_array_pkg::N_MOD-1:0] pwm_pin
);

   localparam int N = counter_array_pkg::N_MOD;

   typedef struct packed {
      logic                                       ack;
      logic [31:0]                                rdata;
      logic                                       run;
      logic [1:0]                                 clk_sel;
      logic [7:0]                                 div_cnt;
      logic                                       upd;
      logic [15:0]                                timer;
      counter_array_pkg::mod_vec_t                flags;
      logic                                       irq;
      counter_array_pkg::module_mode_t [N-1:0]    mode;
      logic [N-1:0][7:0]                          cmp_lo;
      logic [N-1:0][7:0]                          cmp_hi;
   } top_state_t;

   top_state_t                  st_r;
   top_state_t                  st_nxt;
   counter_array_pkg::mod_vec_t match;
   logic [N-1:0][7:0]           duty;
   logic                        rollover;
   logic                        tick;
   logic [7:0]                  div_lim;
   logic                        rd_req;
   logic                        wr_req;
   logic [31:0]                 rd_word;
   logic [7:0]                  in_mode;
   counter_array_pkg::mod_vec_t flag_clr;
   counter_array_pkg::mod_vec_t irq_en;
   logic [3:0]                  mod_sel;
   logic [3:0]                  mod_ofs;

   // Timer source select feeds the enable-pulse divider
   always_comb begin
      unique case (st_r.clk_sel)
         2'd0: div_lim = counter_array_pkg::DIV_SEL0;
         2'd1: div_lim = counter_array_pkg::DIV_SEL1;
         2'd2: div_lim = counter_array_pkg::DIV_SEL2;
         2'd3: div_lim = counter_array_pkg::DIV_SEL3;
      endcase
   end

   assign tick     = st_r.run & (st_r.div_cnt >= div_lim - 8'h01); // R09
   assign rollover = tick & (st_r.timer[7:0] == counter_array_pkg::LOW_MAX);

   always_comb begin
      st_nxt   = st_r;
      rd_word  = counter_array_pkg::WORD_RST;
      in_mode  = 8'h00;
      flag_clr = '0;
      irq_en   = '0;
      mod_sel  = wb_req.adr[7:4];
      mod_ofs  = wb_req.adr[3:0];
      rd_req   = wb_req.cyc & wb_req.stb & ~st_r.ack;
      wr_req   = wb_req.cyc & wb_req.stb & st_r.ack & wb_req.we;

      // Shared timer and its divider
      if (st_r.run) begin
         if (tick) begin
            st_nxt.div_cnt = 8'h00;
            st_nxt.timer   = st_r.timer + 16'h0001; // R08
         end else begin
            st_nxt.div_cnt = st_r.div_cnt + 8'h01;
         end
      end
      st_nxt.upd = tick;

      // Read multiplexer
      if (wb_req.adr == counter_array_pkg::ADR_CTRL) begin
         rd_word[counter_array_pkg::CTRL_RUN_BIT] = st_r.run;
         rd_word[counter_array_pkg::CTRL_SEL_LSB +: 2] = st_r.clk_sel;
         rd_word[counter_array_pkg::CTRL_FLAG_LSB +: N] = st_r.flags;
      end else if (wb_req.adr == counter_array_pkg::ADR_TLOW) begin
         rd_word[7:0] = st_r.timer[7:0]; // R13
      end else if (wb_req.adr == counter_array_pkg::ADR_THIGH) begin
         rd_word[7:0] = st_r.timer[15:8]; // R13
      end
      for (int i = 0; i < N; i++) begin
         if (mod_sel == counter_array_pkg::MOD_FIRST + 4'(i)) begin
            if (mod_ofs == counter_array_pkg::OFS_MODE) begin
               rd_word[counter_array_pkg::MODE_IRQ_BIT] =
                  st_r.mode[i].module_event_irq_enable;
               rd_word[counter_array_pkg::MODE_PWM_BIT] = st_r.mode[i].pwm_mode;
               rd_word[counter_array_pkg::MODE_MATCH_BIT] = st_r.mode[i].match_enable;
               rd_word[counter_array_pkg::MODE_CE_BIT] = st_r.mode[i].compare_enable; // R07
            end else if (mod_ofs == counter_array_pkg::OFS_CLOW) begin
               rd_word[7:0] = st_r.cmp_lo[i];
            end else if (mod_ofs == counter_array_pkg::OFS_CHIGH) begin
               rd_word[7:0] = st_r.cmp_hi[i];
            end else if (mod_ofs == counter_array_pkg::OFS_DUTY) begin
               rd_word[7:0] = duty[i];
            end
         end
      end

      // Bus handshake: ack one cycle after the request, data registered
      st_nxt.ack = rd_req;
      if (rd_req) begin
         st_nxt.rdata = rd_word;
      end

      // Register writes at the edge where the master samples ack
      if (wr_req) begin
         if (wb_req.adr == counter_array_pkg::ADR_CTRL) begin
            if (wb_req.sel[0]) begin
               st_nxt.run     = wb_req.dat[counter_array_pkg::CTRL_RUN_BIT];
               st_nxt.clk_sel = wb_req.dat[counter_array_pkg::CTRL_SEL_LSB +: 2]; // R09
               st_nxt.div_cnt = 8'h00;
            end
            if (wb_req.sel[1]) begin
               flag_clr = wb_req.dat[counter_array_pkg::CTRL_FLAG_LSB +: N];
            end
         end else if (wb_req.sel[0] && !st_r.run) begin
            // Timer is preset only while stopped
            if (wb_req.adr == counter_array_pkg::ADR_TLOW) begin
               st_nxt.timer[7:0] = wb_req.dat[7:0];
            end else if (wb_req.adr == counter_array_pkg::ADR_THIGH) begin
               st_nxt.timer[15:8] = wb_req.dat[7:0];
            end
         end
         for (int i = 0; i < N; i++) begin
            if (mod_sel == counter_array_pkg::MOD_FIRST + 4'(i) && wb_req.sel[0]) begin
               in_mode = wb_req.dat[7:0];
               if (mod_ofs == counter_array_pkg::OFS_MODE) begin
                  st_nxt.mode[i].module_event_irq_enable =
                     in_mode[counter_array_pkg::MODE_IRQ_BIT];
                  st_nxt.mode[i].pwm_mode = in_mode[counter_array_pkg::MODE_PWM_BIT];
                  st_nxt.mode[i].match_enable = in_mode[counter_array_pkg::MODE_MATCH_BIT];
                  st_nxt.mode[i].compare_enable = in_mode[counter_array_pkg::MODE_CE_BIT]; // R07
               end else if (mod_ofs == counter_array_pkg::OFS_CLOW) begin
                  st_nxt.cmp_lo[i] = in_mode;
                  st_nxt.mode[i].compare_enable = 1'b0; // R04
               end else if (mod_ofs == counter_array_pkg::OFS_CHIGH) begin
                  st_nxt.cmp_hi[i] = in_mode;
                  st_nxt.mode[i].compare_enable = 1'b1; // R05
               end
            end
         end
      end

      // Event flags: a new match wins over a clear in the same cycle
      st_nxt.flags = (st_r.flags & ~flag_clr) | match; // R14
      for (int i = 0; i < N; i++) begin
         irq_en[i] = st_r.mode[i].module_event_irq_enable;
      end
      st_nxt.irq = |(st_r.flags & irq_en); // R02
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r.ack     <= 1'b0;
         st_r.rdata   <= counter_array_pkg::WORD_RST;
         st_r.run     <= 1'b0;
         st_r.clk_sel <= 2'd0;
         st_r.div_cnt <= 8'h00;
         st_r.upd     <= 1'b0;
         st_r.timer   <= counter_array_pkg::TIMER_RST; // R13
         st_r.flags   <= '0;
         st_r.irq     <= 1'b0;
         st_r.mode    <= {N{counter_array_pkg::MODE_RST}};
         st_r.cmp_lo  <= {N{counter_array_pkg::BYTE_RST}};
         st_r.cmp_hi  <= {N{counter_array_pkg::BYTE_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // One compare / PWM module per channel, all on the shared timer
   for (genvar g = 0; g < N; g++) begin : g_mod
      compare_pwm_channel u_chan (
         .clock             (clock),
         .rst_n             (rst_n),
         .mode              (st_r.mode[g]),
         .compare_low_byte  (st_r.cmp_lo[g]),
         .compare_high_byte (st_r.cmp_hi[g]),
         .timer             (st_r.timer),
         .timer_upd         (st_r.upd),
         .rollover          (rollover),
         .match             (match[g]),
         .pwm_pin           (pwm_pin[g]),
         .duty_active_byte  (duty[g])
      );
   end

   assign wb_ack    = st_r.ack;
   assign wb_dat_r  = st_r.rdata;
   assign event_irq = st_r.irq;

endmodule

// ### verification/counter_array_sva.sv
// Bus and event checks on the counter array top ports.
// Assumes the top module counter_array with its package ports.
`timescale 1ns/1ps
module counter_array_sva (
   input wire logic                                clock,
   input wire logic                                rst_n,
   input wire counter_array_pkg::wb_req_t          wb_req,
   input wire logic [31:0]                         wb_dat_r,
   input wire logic                                wb_ack,
   input wire logic                                event_irq,
   input wire logic [counter_array_pkg::N_MOD-1:0] pwm_pin
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
      else $error("request not answered next cycle");
   a_ack_pulse: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack |-> $past(wb_req.cyc && wb_req.stb))
      else $error("ack without request");
   a_reset_quiet: assert property ($rose(rst_n) |-> !wb_ack && !event_irq && pwm_pin == '0)
      else $error("outputs active after reset");
   a_data_hold: assert property ($changed(wb_dat_r) |-> wb_ack)
      else $error("read data moved without ack");
   a_unmapped_zero: assert property (wb_ack && $past(!wb_req.we && wb_req.adr == 8'h04)
      |-> wb_dat_r == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_spare: assert property (wb_ack && $past(!wb_req.we && wb_req.adr == 8'h00)
      |-> wb_dat_r[31:13] == '0 && wb_dat_r[7:3] == '0)
      else $error("control spare bits set");
   a_irq_clear: assert property ($fell(event_irq)
      |-> $past(wb_ack && wb_req.we) || $past(wb_ack && wb_req.we, 2))
      else $error("event request dropped without write");
   c_irq: cover property ($rose(event_irq));
   c_write: cover property (wb_ack && wb_req.we);
   c_pwm: cover property ($rose(pwm_pin[0]));
endmodule
bind counter_array counter_array_sva chk (.clock(clock), .rst_n(rst_n), .wb_req(wb_req),
   .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .event_irq(event_irq), .pwm_pin(pwm_pin));

// ### verification/pwm_sink.sv
// Load on the module output pins: counts cycles each pin is high.
// Assumes pins are sampled on the array clock.
`timescale 1ns/1ps
module pwm_sink (
   input  wire logic                                clock,
   input  wire logic                                rst_n,
   input  wire logic                                clear,
   input  wire logic [counter_array_pkg::N_MOD-1:0] pwm_pin,
   output int                                       high_cnt [counter_array_pkg::N_MOD]
);
   always_ff @(posedge clock or negedge rst_n) begin
      for (int i = 0; i < counter_array_pkg::N_MOD; i++) begin
         if (!rst_n || clear) high_cnt[i] <= 0;
         else high_cnt[i] <= high_cnt[i] + int'(pwm_pin[i]);
      end
   end
endmodule

// ### verification/counter_array_test.sv
// Self-checking bench: Wishbone register traffic, compare match, PWM duty.
// Assumes counter_array, its package and the pin load model.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("unexpected at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module counter_array_test;
   logic                                clock = 1'b0;
   logic                                rst_n = 1'b0;
   logic                                clr = 1'b0;
   counter_array_pkg::wb_req_t          req = '0;
   logic [31:0]                         dat_r;
   logic [31:0]                         q;
   logic                                ack;
   logic                                irq;
   logic [counter_array_pkg::N_MOD-1:0] pins;
   logic [7:0]                          duty [counter_array_pkg::N_MOD];
   int                                  high_cnt [counter_array_pkg::N_MOD];
   int                                  fails = 0;
   int                                  check_count = 0;
   int                                  seed = 66;
   int                                  div;
   always #5 clock = ~clock;
   counter_array dut (.clock(clock), .rst_n(rst_n), .wb_req(req), .wb_dat_r(dat_r),
      .wb_ack(ack), .event_irq(irq), .pwm_pin(pins));
   pwm_sink sink (.clock(clock), .rst_n(rst_n), .clear(clr), .pwm_pin(pins),
      .high_cnt(high_cnt));
   task automatic results();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clock);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
      // Wait for the answer; only the watchdog ends a hung wait
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      q = dat_r;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask
   function automatic logic [7:0] mad(int n, logic [3:0] o);
      return {counter_array_pkg::MOD_FIRST + 4'(n), o};
   endfunction
   // Pin model: cycles high in one period of the timer low byte
   function automatic int pwm_high(int d, int dv, bit on);
      int h;
      h = 0;
      for (int t = 0; t < 256; t++) begin
         if (on && t >= d) h += dv;
      end
      return h;
   endfunction
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      results();
   end
   initial begin
      int n;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      wb(0, counter_array_pkg::ADR_TLOW, 0, 4'h1);
      `CHK(q, 32'h0)
      wb(0, counter_array_pkg::ADR_THIGH, 0, 4'h1);
      `CHK(q, 32'h0)
      wb(0, 8'h04, 0, 4'h1);
      `CHK(q, 32'h0)
      for (int m = 0; m < counter_array_pkg::N_MOD; m++) begin
         wb(1, mad(m, 4'h0), 32'h48, 4'h1);
         wb(0, mad(m, 4'h0), 0, 4'h1);
         `CHK(q, 32'h48)
         wb(1, mad(m, 4'h4), $random(seed), 4'h1);
         wb(0, mad(m, 4'h0), 0, 4'h1);
         `CHK(q, 32'h08)
         wb(1, mad(m, 4'h8), $random(seed), 4'h1);
         wb(0, mad(m, 4'h0), 0, 4'h1);
         `CHK(q, 32'h48)
         wb(1, mad(m, 4'h0), 32'h0, 4'h1);
         wb(0, mad(m, 4'h0), 0, 4'h1);
         `CHK(q, 32'h0)
         duty[m] = 8'($random(seed));
      end
      // Compare at 0x0110 with event request enabled
      wb(1, mad(0, 4'h0), 32'h09, 4'h1);
      wb(1, mad(0, 4'h4), 32'h10, 4'h1);
      wb(1, mad(0, 4'h8), 32'h01, 4'h1);
      wb(1, counter_array_pkg::ADR_CTRL, 32'h1, 4'h1);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      `CHK(irq, 1'b1)
      // Compare value, then match, flag and request stages plus the sampling edge
      `CHK(n, 16'h0110 + 4)
      wb(1, counter_array_pkg::ADR_CTRL, 32'h0, 4'h1);
      wb(0, counter_array_pkg::ADR_CTRL, 0, 4'h1);
      `CHK(q[12:8], 5'h01)
      wb(1, counter_array_pkg::ADR_CTRL, 32'h100, 4'h2);
      repeat (3) @(posedge clock);
      `CHK(irq, 1'b0)
      wb(0, counter_array_pkg::ADR_CTRL, 0, 4'h1);
      `CHK(q[12:8], 5'h00)
      wb(1, counter_array_pkg::ADR_TLOW, 32'h0, 4'h1);
      wb(1, counter_array_pkg::ADR_THIGH, 32'h0, 4'h1);
      for (int m = 0; m < counter_array_pkg::N_MOD; m++) begin
         wb(1, mad(m, 4'h4), 32'h0, 4'h1);
         wb(1, mad(m, 4'h8), {24'h0, duty[m]}, 4'h1);
         wb(1, mad(m, 4'h0), (m == 4) ? 32'h02 : 32'h42, 4'h1);
      end
      for (int s = 0; s < 2; s++) begin
         div = s ? int'(counter_array_pkg::DIV_SEL1) : int'(counter_array_pkg::DIV_SEL0);
         wb(1, counter_array_pkg::ADR_CTRL, {29'h0, 2'(s), 1'b1}, 4'h1);
         repeat (600 * div) @(posedge clock);
         wb(1, mad(0, 4'hc), 32'h0, 4'h1);
         for (int m = 0; m < counter_array_pkg::N_MOD; m++) begin
            wb(0, mad(m, 4'hc), 0, 4'h1);
            `CHK(q[7:0], duty[m])
         end
         @(posedge clock) clr <= 1'b1;
         @(posedge clock) clr <= 1'b0;
         repeat (256 * div) @(posedge clock);
         #1;
         for (int m = 0; m < counter_array_pkg::N_MOD; m++) begin
            `CHK(high_cnt[m], pwm_high(int'(duty[m]), div, m != 4))
         end
         `CHK(^pins !== 1'bx, 1'b1)
      end
      results();
   end
endmodule
